// *** tcf_pkg.sv ***
// package: constants, types and helpers of the eight-bit timer/counter block
// Contract
// - run bit rising starts; writing zero stops, clears
// - clock field picks divided high clock or pin
// - divider bits double ratio or pick low/8
// - mode field: timer, reserved, divider, pwm
// - stop power mode entry clears run bit
// - control bits 7 and 6 read undefined; here they read zero
// - timer mode counts each internal clock tick
// - match raises interrupt, clears counter, resumes
// - event mode counts rises, matches at fall
package tcf_pkg;

  // ----------------------------------------------------------------
  // register map and reset values
  // ----------------------------------------------------------------
  localparam int             TCF_ADDR_W     = 8;
  localparam logic [7:0]     TCF_CTRL_ADDR  = 8'h14;
  localparam logic [7:0]     TCF_CMP_ADDR   = 8'h18;
  localparam logic [7:0]     TCF_STAT_ADDR  = 8'h1c;
  localparam logic [7:0]     TCF_MASK_ADDR  = 8'h20;
  localparam logic [7:0]     TCF_CFG_ADDR   = 8'h24;
  localparam logic [7:0]     TCF_CNT_ADDR   = 8'h28;
  localparam logic [5:0]     TCF_CTRL_RST   = 6'h00;
  localparam logic [7:0]     TCF_CMP_RST    = 8'hff;
  localparam logic [7:0]     TCF_CNT_MAX    = 8'hff;
  localparam logic [1:0]     TCF_RESP_OKAY  = 2'b00;
  localparam logic [1:0]     TCF_RESP_SLVERR = 2'b10;
  localparam int             TCF_DIV_W      = 12;
  localparam logic [2:0]     TCF_LOW_DIV_LAST = 3'h7;

  // clock select codes with special meaning
  localparam logic [2:0]     TCF_CK_SLOWEST = 3'b000;
  localparam logic [2:0]     TCF_CK_UNDIV   = 3'b110;
  localparam logic [2:0]     TCF_CK_EXT     = 3'b111;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCF_MODE_TIMER  = 2'b00,
    TCF_MODE_RSVD   = 2'b01,
    TCF_MODE_DIVOUT = 2'b10,
    TCF_MODE_PWM    = 2'b11
  } tcf_mode_type;

  typedef enum logic {
    TCF_WR_COLLECT = 1'b0,
    TCF_WR_RESP    = 1'b1
  } tcf_wr_state_type;

  // control register, bits 5..0 (bits 7..6 are not stored)
  typedef struct packed {
    logic         run;
    logic [2:0]   cksel;
    tcf_mode_type mode;
  } tcf_ctrl_type;

  // divider and power configuration register, bits 2..0
  typedef struct packed {
    logic low_power;
    logic second_div;
    logic first_div;
  } tcf_cfg_type;

  typedef struct packed {
    logic                  awvalid;
    logic [TCF_ADDR_W-1:0] awaddr;
    logic                  wvalid;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bready;
    logic                  arvalid;
    logic [TCF_ADDR_W-1:0] araddr;
    logic                  rready;
  } tcf_axil_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tcf_axil_rsp_type;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // base divide exponent for each high-clock code
  function automatic logic [3:0] tcf_div_exp(input logic [2:0] code);
    unique case (code)
      3'b000:  tcf_div_exp = 4'd11;
      3'b001:  tcf_div_exp = 4'd7;
      3'b010:  tcf_div_exp = 4'd5;
      3'b011:  tcf_div_exp = 4'd3;
      3'b100:  tcf_div_exp = 4'd2;
      3'b101:  tcf_div_exp = 4'd1;
      default: tcf_div_exp = 4'd0;
    endcase
  endfunction

  // true for every mapped register address
  function automatic logic tcf_addr_hit(input logic [TCF_ADDR_W-1:0] a);
    tcf_addr_hit = (a == TCF_CTRL_ADDR) || (a == TCF_CMP_ADDR)  ||
                   (a == TCF_STAT_ADDR) || (a == TCF_MASK_ADDR) ||
                   (a == TCF_CFG_ADDR)  || (a == TCF_CNT_ADDR);
  endfunction

endpackage

// *** tcf_edge.sv ***
// module: edge detector for a synchronous input pin
`timescale 1ns/1ps
module tcf_edge import tcf_pkg::*; (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // pin and edges
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic prev;
  } tcf_edge_st_type;

  tcf_edge_st_type st_ff;
  tcf_edge_st_type nxt_st;

  // remember last sample
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = pin_in;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // pin is taken as synchronous, so no extra stages
  assign rise = pin_in & ~st_ff.prev;
  assign fall = ~pin_in & st_ff.prev;

endmodule // tcf_edge

// *** tcf_prescaler.sv ***
// module: count clock source selection and division
`timescale 1ns/1ps
module tcf_prescaler import tcf_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // selection
  input  wire logic [2:0] cksel,
  input  wire tcf_cfg_type cfg,
  input  wire logic       low_rise,
  // count tick
  output logic            tick
);

  typedef struct packed {
    logic [TCF_DIV_W-1:0] div_cnt;
    logic [2:0]           low_cnt;
  } tcf_pre_st_type;

  tcf_pre_st_type st_ff;
  tcf_pre_st_type nxt_st;

  logic [3:0]           exp_sel;
  logic [TCF_DIV_W-1:0] div_mask;
  logic                 hi_tick;
  logic                 low_tick;

  // free-running dividers; a start does not realign them, so the
  // first tick after start may come early by up to one period
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.div_cnt = st_ff.div_cnt + 1'b1;
    if (low_rise) begin
      nxt_st.low_cnt = st_ff.low_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // second divider bit doubles each high-clock ratio
  assign exp_sel  = tcf_div_exp(cksel) + {3'h0, cfg.second_div};
  assign div_mask = TCF_DIV_W'((13'h1 << exp_sel) - 13'h1);
  assign hi_tick  = ((st_ff.div_cnt & div_mask) == div_mask);
  assign low_tick = low_rise && (st_ff.low_cnt == TCF_LOW_DIV_LAST);

  // source choice: slow power modes allow only low clock / 8;
  // the first divider bit moves code 000 onto the low clock
  always_comb begin
    if (cfg.low_power) begin
      tick = (cksel == TCF_CK_SLOWEST) && low_tick;
    end else if ((cksel == TCF_CK_SLOWEST) && cfg.first_div) begin
      tick = low_tick;
    end else if (cksel == TCF_CK_EXT) begin
      tick = 1'b0;
    end else begin
      tick = hi_tick;
    end
  end

endmodule // tcf_prescaler

// *** tcf_timer_top.sv ***
// module: eight-bit timer/counter with AXI4-Lite register access
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module tcf_timer_top import tcf_pkg::*; (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // register bus
  input  wire tcf_axil_req_type  axil_req,
  output tcf_axil_rsp_type       axil_rsp,
  // pins and power events
  input  wire logic              external_count_input,
  input  wire logic              low_freq_clock,
  input  wire logic              stop_mode_enter,
  // interrupt
  output logic                   irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    tcf_axil_rsp_type      rsp;
    tcf_wr_state_type      wr_state;
    logic                  aw_full;
    logic [TCF_ADDR_W-1:0] awaddr;
    logic                  w_full;
    logic [7:0]            wdata;
    logic                  wstrb0;
    tcf_ctrl_type          ctrl;
    logic [7:0]            cmp;
    logic                  status;
    logic                  mask;
    tcf_cfg_type           cfg;
    logic [7:0]            cnt;
    logic                  irq;
  } tcf_top_st_type;

  tcf_top_st_type st_ff;
  tcf_top_st_type nxt_st;

  logic tick;
  logic ext_rise;
  logic ext_fall;
  logic low_rise;
  logic do_wr;
  logic wr_hit;
  logic match_ev;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // read view; upper control bits simply read zero
  function automatic logic [31:0] rd_value(input tcf_top_st_type s,
                                           input logic [TCF_ADDR_W-1:0] a);
    rd_value = 32'h0;
    unique case (a)
      TCF_CTRL_ADDR: rd_value = {26'h0, s.ctrl};
      TCF_CMP_ADDR:  rd_value = {24'h0, s.cmp};
      TCF_STAT_ADDR: rd_value = {31'h0, s.status};
      TCF_MASK_ADDR: rd_value = {31'h0, s.mask};
      TCF_CFG_ADDR:  rd_value = {29'h0, s.cfg};
      TCF_CNT_ADDR:  rd_value = {24'h0, s.cnt};
      default:       rd_value = 32'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  // external count pin edges
  tcf_edge u_ext_edge (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  (external_count_input),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  // low-frequency clock edges feed the /8 path
  tcf_edge u_low_edge (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  (low_freq_clock),
    .rise    (low_rise),
    .fall    ()
  );

  tcf_prescaler u_pre (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .cksel    (st_ff.ctrl.cksel),
    .cfg      (st_ff.cfg),
    .low_rise (low_rise),
    .tick     (tick)
  );

  assign do_wr  = st_ff.aw_full && st_ff.w_full && (st_ff.wr_state == TCF_WR_COLLECT);
  assign wr_hit = tcf_addr_hit(st_ff.awaddr);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st   = st_ff;
    match_ev = 1'b0;

    // write address and data are taken in either order
    if (axil_req.awvalid && st_ff.rsp.awready) begin
      nxt_st.aw_full = 1'b1;
      nxt_st.awaddr  = axil_req.awaddr;
    end
    if (axil_req.wvalid && st_ff.rsp.wready) begin
      nxt_st.w_full = 1'b1;
      nxt_st.wdata  = axil_req.wdata[7:0];
      nxt_st.wstrb0 = axil_req.wstrb[0];
    end

    // response retires first, then a new write may be performed
    if (st_ff.rsp.bvalid && axil_req.bready) begin
      nxt_st.rsp.bvalid = 1'b0;
      nxt_st.wr_state   = TCF_WR_COLLECT;
    end
    if (do_wr) begin
      nxt_st.aw_full   = 1'b0;
      nxt_st.w_full    = 1'b0;
      nxt_st.wr_state  = TCF_WR_RESP;
      nxt_st.rsp.bvalid = 1'b1;
      nxt_st.rsp.bresp = wr_hit ? TCF_RESP_OKAY : TCF_RESP_SLVERR;
    end

    // register writes; only the low byte lane carries data
    if (do_wr && wr_hit && st_ff.wstrb0) begin
      unique case (st_ff.awaddr)
        TCF_CTRL_ADDR: nxt_st.ctrl = tcf_ctrl_type'(st_ff.wdata[5:0]);
        TCF_CMP_ADDR:  nxt_st.cmp  = st_ff.wdata;
        TCF_STAT_ADDR: begin
          if (st_ff.wdata[0]) begin
            nxt_st.status = 1'b0;
          end
        end
        TCF_MASK_ADDR: nxt_st.mask = st_ff.wdata[0];
        TCF_CFG_ADDR:  nxt_st.cfg  = tcf_cfg_type'(st_ff.wdata[2:0]);
        default:       nxt_st.cnt  = st_ff.cnt;
      endcase
    end

    // stop power mode overrides any software start
    if (stop_mode_enter) begin
      nxt_st.ctrl.run = 1'b0;
    end

    // read channel: one outstanding read
    if (st_ff.rsp.rvalid && axil_req.rready) begin
      nxt_st.rsp.rvalid = 1'b0;
    end
    if (axil_req.arvalid && st_ff.rsp.arready) begin
      nxt_st.rsp.rvalid = 1'b1;
      nxt_st.rsp.rdata  = rd_value(st_ff, axil_req.araddr);
      nxt_st.rsp.rresp  = tcf_addr_hit(axil_req.araddr) ? TCF_RESP_OKAY : TCF_RESP_SLVERR;
    end

    // counting per mode while running
    if (st_ff.ctrl.run) begin
      unique case (st_ff.ctrl.mode)
        TCF_MODE_TIMER: begin
          if (st_ff.ctrl.cksel == TCF_CK_EXT) begin
            // event counting: rise counts, match seen at the fall
            if (ext_fall && (st_ff.cnt == st_ff.cmp)) begin
              nxt_st.cnt = 8'h00;
              match_ev   = 1'b1;
            end else if (ext_rise) begin
              nxt_st.cnt = st_ff.cnt + 1'b1;
            end
          end else if (tick) begin
            if (st_ff.cnt == st_ff.cmp) begin
              nxt_st.cnt = 8'h00;
              match_ev   = 1'b1;
            end else begin
              nxt_st.cnt = st_ff.cnt + 1'b1;
            end
          end
        end
        TCF_MODE_DIVOUT: begin
          // same match-and-clear cadence; output pin not modelled
          if (tick) begin
            if (st_ff.cnt == st_ff.cmp) begin
              nxt_st.cnt = 8'h00;
              match_ev   = 1'b1;
            end else begin
              nxt_st.cnt = st_ff.cnt + 1'b1;
            end
          end
        end
        TCF_MODE_PWM: begin
          // free run, interrupt at overflow; output pin not modelled
          if (tick) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
            match_ev   = (st_ff.cnt == TCF_CNT_MAX);
          end
        end
        TCF_MODE_RSVD: begin
          nxt_st.cnt = 8'h00;
        end
      endcase
    end

    // stopped (or being stopped) counter holds zero
    if (!nxt_st.ctrl.run) begin
      nxt_st.cnt = 8'h00;
    end

    // sticky status: a new event wins over a same-cycle clear
    if (match_ev) begin
      nxt_st.status = 1'b1;
    end
    nxt_st.irq = nxt_st.status & nxt_st.mask;

    // ready flags follow the next occupancy
    nxt_st.rsp.awready = !nxt_st.aw_full && (nxt_st.wr_state == TCF_WR_COLLECT);
    nxt_st.rsp.wready  = !nxt_st.w_full && (nxt_st.wr_state == TCF_WR_COLLECT);
    nxt_st.rsp.arready = !nxt_st.rsp.rvalid;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff          <= '0;
      st_ff.ctrl     <= tcf_ctrl_type'(TCF_CTRL_RST);
      st_ff.cmp      <= TCF_CMP_RST;
      st_ff.wr_state <= TCF_WR_COLLECT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign axil_rsp = st_ff.rsp;
  assign irq      = st_ff.irq;

endmodule // tcf_timer_top

// *** tcf_pin_model.sv ***
// model: external event pin and low-frequency clock source
`timescale 1ns/1ps
module tcf_pin_model (
  // clock
  input  wire logic clk,
  // pins toward the timer
  output logic      ext_pin,
  output logic      low_pin
);
  // both lines idle low; the low clock stands still between bursts
  initial begin
    ext_pin = 1'b0;
    low_pin = 1'b0;
  end

  // n pulses of w cycles high and w low on the chosen pin
  task automatic pulse(input bit sel, input int n, input int w);
    repeat (n) begin
      @(posedge clk);
      if (sel) low_pin <= 1'b1;
      else ext_pin <= 1'b1;
      repeat (w) @(posedge clk);
      if (sel) low_pin <= 1'b0;
      else ext_pin <= 1'b0;
      repeat (w - 1) @(posedge clk);
    end
  endtask
endmodule // tcf_pin_model

// *** tcf_timer_top_properties.sv ***
// checker: bus timing, read-back and reset properties of the timer
`timescale 1ns/1ps
module tcf_timer_top_properties import tcf_pkg::*; (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // bus, pins and interrupt
  input  wire tcf_axil_req_type axil_req,
  input  wire tcf_axil_rsp_type axil_rsp,
  input  wire logic             external_count_input,
  input  wire logic             low_freq_clock,
  input  wire logic             stop_mode_enter,
  input  wire logic             irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [7:0] rd_addr_ff;
  logic       stop_ff;
  logic       stop_rd_ff;
  wire        ar_hs = axil_req.arvalid && axil_rsp.arready;
  wire        aw_hs = axil_req.awvalid && axil_rsp.awready;
  wire        w_hs  = axil_req.wvalid && axil_rsp.wready;

  // ----------------------------------------------------------------
  // history: read address, stop seen since last control write
  // ----------------------------------------------------------------
  // flag clears early at the control address, so it over-claims only if a stop comes before that write lands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_addr_ff <= 8'h00;
      stop_ff    <= 1'b0;
      stop_rd_ff <= 1'b0;
    end else begin
      if (ar_hs) begin
        rd_addr_ff <= axil_req.araddr;
        stop_rd_ff <= stop_ff;
      end
      if (stop_mode_enter) stop_ff <= 1'b1;
      else if (aw_hs && axil_req.awaddr == TCF_CTRL_ADDR) stop_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_read_lat: assert property (ar_hs |=> axil_rsp.rvalid)
    else $error("read answer late");
  chk_write_lat: assert property (aw_hs && w_hs |-> ##2 axil_rsp.bvalid)
    else $error("write answer late");
  chk_b_hold: assert property (axil_rsp.bvalid && !axil_req.bready
    |=> axil_rsp.bvalid && $stable(axil_rsp.bresp)) else $error("write answer dropped");
  chk_r_hold: assert property (axil_rsp.rvalid && !axil_req.rready
    |=> axil_rsp.rvalid && $stable(axil_rsp.rdata)) else $error("read answer dropped");
  chk_ar_block: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
    else $error("read taken while answer pends");
  chk_aw_block: assert property (axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready)
    else $error("write taken while answer pends");
  chk_bad_addr: assert property (axil_rsp.rvalid && !tcf_addr_hit(rd_addr_ff)
    |-> axil_rsp.rresp == TCF_RESP_SLVERR && axil_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_ctrl_top: assert property (
    axil_rsp.rvalid && rd_addr_ff == TCF_CTRL_ADDR |-> axil_rsp.rdata[31:6] == 26'h0)
    else $error("control upper bits not zero");
  chk_stop_run: assert property (
    axil_rsp.rvalid && rd_addr_ff == TCF_CTRL_ADDR && stop_rd_ff |-> !axil_rsp.rdata[5])
    else $error("run bit survived stop mode");
  chk_stop_cnt: assert property (
    axil_rsp.rvalid && rd_addr_ff == TCF_CNT_ADDR && stop_rd_ff |-> axil_rsp.rdata == 32'h0)
    else $error("counter not cleared by stop");
  chk_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |=> !irq && !axil_rsp.bvalid && !axil_rsp.rvalid)
    else $error("outputs active after reset");

  cov_irq: cover property ($rose(irq));
  cov_stop: cover property (stop_mode_enter);
  cov_bad: cover property (axil_rsp.rvalid && axil_rsp.rresp == TCF_RESP_SLVERR);
endmodule // tcf_timer_top_properties

bind tcf_timer_top tcf_timer_top_properties i_tcf_timer_top_properties (
  .clk(clk), .sys_rst(sys_rst), .axil_req(axil_req), .axil_rsp(axil_rsp),
  .external_count_input(external_count_input), .low_freq_clock(low_freq_clock),
  .stop_mode_enter(stop_mode_enter), .irq(irq));

// *** tcf_timer_top_tb_top.sv ***
// testbench: register-level tests of the timer/counter
`timescale 1ns/1ps
module tcf_timer_top_tb_top import tcf_pkg::*;;
  logic             clk = 1'b0;
  logic             sys_rst;
  logic             stop_in;
  tcf_axil_req_type rq;
  tcf_axil_rsp_type rs;
  wire logic        ext_pin;
  wire logic        low_pin;
  wire logic        irq_o;
  logic [31:0]      d;
  logic [1:0]       r;
  logic [7:0]       cv;
  int               bad_count;
  int               num_checks;
  int               cyc = 0;
  int               ar_cyc;
  int               b_cyc;
  int               ex[7] = '{11, 7, 5, 3, 2, 1, 0};

  // 20 MHz clock and a cycle count for tick estimates
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  tcf_timer_top i_tcf_timer_top (.clk(clk), .sys_rst(sys_rst), .axil_req(rq), .axil_rsp(rs),
    .external_count_input(ext_pin), .low_freq_clock(low_pin), .stop_mode_enter(stop_in),
    .irq(irq_o));
  tcf_pin_model i_tcf_pin_model (.clk(clk), .ext_pin(ext_pin), .low_pin(low_pin));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ready is sampled mid-cycle, so the release lands right after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ta, tw, tb;
    @(posedge clk);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= {24'h0, v};
    rq.bready <= 1'b1;
    for (int n = 0; n <= 100; n++) begin
      if (n == 100) begin
        bad_count++;
        test_done();
      end
      @(negedge clk);
      ta = rq.awvalid && rs.awready;
      tw = rq.wvalid && rs.wready;
      tb = rs.bvalid;
      r = rs.bresp;
      @(posedge clk);
      if (ta) rq.awvalid <= 1'b0;
      if (tw) rq.wvalid <= 1'b0;
      if (tb) begin
        rq.bready <= 1'b0;
        b_cyc = cyc;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    for (int n = 0; n <= 100; n++) begin
      if (n == 100) begin
        bad_count++;
        test_done();
      end
      @(negedge clk);
      ta = rq.arvalid && rs.arready;
      tr = rs.rvalid;
      d = rs.rdata;
      r = rs.rresp;
      @(posedge clk);
      if (ta) begin
        rq.arvalid <= 1'b0;
        ar_cyc = cyc;
      end
      if (tr) begin
        rq.rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask

  task automatic chk_irq(input logic exp);
    @(negedge clk);
    chk({31'h0, irq_o}, {31'h0, exp});
  endtask

  // fields first, then run; ticks estimated from elapsed cycles, one either way
  // codes above 011 are legal only in pwm mode, which counts alike here
  task automatic rate(input logic [2:0] cfg, input logic [2:0] code, input int e);
    int x;
    logic [1:0] md;
    md = (code > 3'h3) ? 2'h3 : 2'h0;
    wr(TCF_CFG_ADDR, {5'h0, cfg});
    wr(TCF_CTRL_ADDR, {3'h0, code, md});
    wr(TCF_CTRL_ADDR, {3'h1, code, md});
    repeat ((3 << e) + 10) @(posedge clk);
    rd(TCF_CNT_ADDR);
    x = (ar_cyc - b_cyc + 1) >> e;
    chk({31'h0, (d + 1 >= x) && (d <= x + 1)}, 32'h1);
    wr(TCF_CTRL_ADDR, {3'h0, code, md});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rq = '0;
    rq.wstrb = 4'hf;
    sys_rst = 1'b1;
    stop_in = 1'b0;
    bad_count = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(TCF_CTRL_ADDR, 32'h0);
    rdc(TCF_CMP_ADDR, 32'hff);
    rdc(TCF_CNT_ADDR, 32'h0);
    rdc(TCF_STAT_ADDR, 32'h0);
    rdc(TCF_MASK_ADDR, 32'h0);
    rdc(TCF_CFG_ADDR, 32'h0);
    rdc(8'h30, 32'h0);
    chk({30'h0, r}, {30'h0, TCF_RESP_SLVERR});
    wr(8'h30, 8'h5a);
    chk({30'h0, r}, {30'h0, TCF_RESP_SLVERR});
    wr(TCF_CNT_ADDR, 8'h33);
    rdc(TCF_CNT_ADDR, 32'h0);
    // undivided code 110 stays unused: this clock is above its limit
    for (int c = 0; c < 6; c++) for (int f = 0; f < 2; f++) rate(3'(2 * f), 3'(c), ex[c] + f);
    // low clock divided by eight on code 000, running while selected
    wr(TCF_CFG_ADDR, 8'h01);
    rdc(TCF_CFG_ADDR, 32'h1);
    wr(TCF_CTRL_ADDR, 8'h20);
    i_tcf_pin_model.pulse(1'b1, 24, 2);
    rd(TCF_CNT_ADDR);
    chk({31'h0, d >= 2 && d <= 4}, 32'h1);
    wr(TCF_CTRL_ADDR, 8'h00);
    wr(TCF_CFG_ADDR, 8'h04);
    wr(TCF_CTRL_ADDR, 8'h0c);
    wr(TCF_CTRL_ADDR, 8'h2c);
    repeat (100) @(posedge clk);
    rdc(TCF_CNT_ADDR, 32'h0);
    wr(TCF_CTRL_ADDR, 8'h0c);
    wr(TCF_CFG_ADDR, 8'h00);
    // every mode code; only the reserved one stays idle
    for (int m = 0; m < 4; m++) begin
      cv = ((m == 0 || m == 3) ? 8'h0c : 8'h08) | 8'(m);
      wr(TCF_CTRL_ADDR, cv);
      rdc(TCF_CTRL_ADDR, {24'h0, cv});
      wr(TCF_CTRL_ADDR, cv | 8'h20);
      repeat (80) @(posedge clk);
      rd(TCF_CNT_ADDR);
      chk({31'h0, d != 0}, {31'h0, m != 1});
      wr(TCF_CTRL_ADDR, cv);
    end
    rdc(TCF_STAT_ADDR, 32'h0);
    // event counting in normal mode: rises count, match at the fall
    wr(TCF_CTRL_ADDR, 8'h1c);
    wr(TCF_CMP_ADDR, 8'h03);
    wr(TCF_MASK_ADDR, 8'h01);
    wr(TCF_CTRL_ADDR, 8'h3c);
    i_tcf_pin_model.pulse(1'b0, 2, 10);
    rdc(TCF_CNT_ADDR, 32'h2);
    i_tcf_pin_model.pulse(1'b0, 1, 10);
    rdc(TCF_CNT_ADDR, 32'h0);
    rdc(TCF_STAT_ADDR, 32'h1);
    chk_irq(1'b1);
    wr(TCF_STAT_ADDR, 8'h01);
    chk_irq(1'b0);
    wr(TCF_MASK_ADDR, 8'h00);
    i_tcf_pin_model.pulse(1'b0, 3, 10);
    rdc(TCF_STAT_ADDR, 32'h1);
    chk_irq(1'b0);
    wr(TCF_MASK_ADDR, 8'h01);
    chk_irq(1'b1);
    wr(TCF_STAT_ADDR, 8'h01);
    wr(TCF_CTRL_ADDR, 8'h1c);
    // timer match on high clock / 8
    wr(TCF_CTRL_ADDR, 8'h0c);
    wr(TCF_CTRL_ADDR, 8'h2c);
    for (int n = 0; n <= 200 && !irq_o; n++) @(negedge clk);
    chk_irq(1'b1);
    rd(TCF_CNT_ADDR);
    chk({31'h0, d <= 3}, 32'h1);
    // stop power mode entry drops the run bit
    @(posedge clk);
    stop_in <= 1'b1;
    @(posedge clk);
    stop_in <= 1'b0;
    rdc(TCF_CTRL_ADDR, 32'h0c);
    rdc(TCF_CNT_ADDR, 32'h0);
    wr(TCF_STAT_ADDR, 8'h01);
    wr(TCF_CTRL_ADDR, 8'h2c);
    wr(TCF_CTRL_ADDR, 8'h0c);
    rdc(TCF_CNT_ADDR, 32'h0);
    test_done();
  end
endmodule // tcf_timer_top_tb_top
